// ===== rtl/twdbg_fifo.sv
// flop-based fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
module twdbg_fifo
	import twdbg_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	twdbg_stream_if.snk wr,
	twdbg_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	wire push = wr.valid && wr.ready;
	wire pop = rd.valid && rd.ready;
	wire [AW-1:0] next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
	wire [AW-1:0] next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;

	assign wr.ready = (count != FULL_CNT);
	assign rd.valid = (count != '0);
	assign rd.data = mem[rptr];

	always_ff @(posedge CLOCK) begin
		if (push) begin
			mem[wptr] <= wr.data;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= next_wptr;
			end
			if (pop) begin
				rptr <= next_rptr;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : twdbg_fifo

// ===== rtl/twdbg_pkg.sv
// constants, types and helpers of the two-wire debug target
// assumes a single core clock domain plus the host-driven link clock
package twdbg_pkg;
	// ------------------------------------------------------------
	// register select values and processor-side addresses
	// ------------------------------------------------------------
	localparam logic [7:0] SEL_PART_ID = 8'h00;
	localparam logic [7:0] SEL_REV = 8'h01;
	localparam logic [7:0] SEL_CTL = 8'h02;
	localparam logic [7:0] SEL_DATA = 8'hb4;
	localparam logic [7:0] ADDR_PART_ID = 8'hfd;
	localparam logic [7:0] ADDR_REV = 8'hfe;
	localparam logic [3:0] SFR_PAGE_DBG = 4'hf;
	// ------------------------------------------------------------
	// reset values and fields
	// ------------------------------------------------------------
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int CTL_EN_BIT = 0;
	// ------------------------------------------------------------
	// flash command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
	localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
	localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
	// ------------------------------------------------------------
	// link framing
	// ------------------------------------------------------------
	localparam logic [1:0] INS_DATA_READ = 2'h0;
	localparam logic [1:0] INS_DATA_WRITE = 2'h1;
	localparam logic [1:0] INS_ADDR_READ = 2'h2;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
	localparam logic [3:0] INS_LAST = 4'h1;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic [3:0] SEND_END = 4'h8;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_WIDTH = 8;

	typedef enum logic [4:0] {
		L_IDLE = 5'h01,
		L_INS = 5'h02,
		L_DATA = 5'h04,
		L_WAIT = 5'h08,
		L_SEND = 5'h10
	} twdbg_link_type;

	typedef enum logic [2:0] {
		FC_NONE = 3'h0,
		FC_READ = 3'h1,
		FC_WRITE = 3'h2,
		FC_PAGE = 3'h3,
		FC_DEVICE = 3'h4
	} twdbg_cmd_type;

	function automatic twdbg_cmd_type twdbg_decode(input logic [7:0] b);
		case (b)
			CMD_BLOCK_READ: twdbg_decode = FC_READ;
			CMD_BLOCK_WRITE: twdbg_decode = FC_WRITE;
			CMD_PAGE_ERASE: twdbg_decode = FC_PAGE;
			CMD_DEVICE_ERASE: twdbg_decode = FC_DEVICE;
			default: twdbg_decode = FC_NONE;
		endcase
	endfunction : twdbg_decode
endpackage : twdbg_pkg

// ===== rtl/twdbg_stream_if.sv
// valid/ready byte stream between the target and its fifo
// assumes both ends on the core clock
interface twdbg_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : twdbg_stream_if

// ===== rtl/twdbg_target.sv
// target-side register set of the two-wire debug and flash port
// assumes DBG_CLK is the shared reset pin clocked by the host, HALTED
// comes from the core clock domain, REV_STRAP is static silicon wiring
// Functional notes
// - The silicon revision register is read-only and is loaded once from the silicon straps after reset.
// - Silicon revision is read at select 0xfe and at processor address 0xfe page 0xf.
// - The programming data register at 0xb4 carries commands, addresses and data.
// - Codes 0x06, 0x07, 0x08 and 0x03 decode to block read, write, page and device erase.
// - While halted the device stalls peripherals and program execution.
// - While halted the reset pin is the debug clock and a user pin the debug data line.
// - A link-only select register picks control at 0x02 or data at 0xb4 for data access.
// - The link is one host clock plus one two-way data line.
module twdbg_target
	import twdbg_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5a, // arbitrary identity value
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic DBG_CLK,
	input wire logic DBG_DATA_IN,
	output logic DBG_DATA_OUT,
	output logic DBG_DATA_OE,
	input wire logic HALTED,
	output logic PERIPH_STALL,
	output logic USER_PIN,
	input wire logic [7:0] REV_STRAP,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [3:0] SFR_PAGE,
	output logic [7:0] SFR_RDATA,
	output logic FLASH_VALID,
	output logic [7:0] FLASH_DATA,
	input wire logic FLASH_READY,
	input wire logic FLASH_RD_VALID,
	input wire logic [7:0] FLASH_RD_DATA,
	output twdbg_cmd_type FP_CMD
);
	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	twdbg_link_type lstate;
	logic halt_l1;
	logic halt_l2;
	logic ack_l1;
	logic ack_l2;
	logic ack_seen;
	logic [1:0] ins;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic [7:0] sel;
	logic req_tog;
	logic req_wr;
	logic [7:0] req_sel;
	logic [7:0] req_wd;
	logic dout;
	logic oe;
	wire [7:0] next_sh = {DBG_DATA_IN, sh[7:1]};
	wire [1:0] next_ins = {DBG_DATA_IN, ins[1]};
	wire ack_new = ack_l2 != ack_seen;

	// core-domain results read by the link after the ack toggle
	logic ack_tog;
	logic [7:0] link_rdata;

	assign DBG_DATA_OUT = dout;
	assign DBG_DATA_OE = oe;

	always_ff @(posedge DBG_CLK or negedge RSTN) begin
		if (!RSTN) begin
			halt_l1 <= 1'b0;
			halt_l2 <= 1'b0;
			ack_l1 <= 1'b0;
			ack_l2 <= 1'b0;
		end else begin
			halt_l1 <= HALTED;
			halt_l2 <= halt_l1;
			ack_l1 <= ack_tog;
			ack_l2 <= ack_l1;
		end
	end

	always_ff @(posedge DBG_CLK or negedge RSTN) begin
		if (!RSTN) begin
			lstate <= L_IDLE;
			ins <= '0;
			cnt <= '0;
			sh <= '0;
			sel <= SEL_RESET;
			req_tog <= 1'b0;
			req_wr <= 1'b0;
			req_sel <= SEL_RESET;
			req_wd <= '0;
			ack_seen <= 1'b0;
			dout <= 1'b0;
			oe <= 1'b0;
		end else if (!halt_l2) begin
			lstate <= L_IDLE;
			oe <= 1'b0;
			dout <= 1'b0;
		end else begin
			case (lstate)
				L_IDLE: begin
					oe <= 1'b0;
					dout <= 1'b0;
					cnt <= '0;
					if (DBG_DATA_IN) begin
						lstate <= L_INS;
					end
				end
				L_INS: begin
					ins <= next_ins;
					cnt <= cnt + 4'h1;
					if (cnt == INS_LAST) begin
						cnt <= '0;
						if (next_ins[0]) begin
							lstate <= L_DATA;
						end else if (next_ins == INS_ADDR_READ) begin
							sh <= sel;
							dout <= 1'b1;
							oe <= 1'b1;
							lstate <= L_SEND;
						end else begin
							req_wr <= 1'b0;
							req_sel <= sel;
							req_tog <= ~req_tog;
							oe <= 1'b1;
							lstate <= L_WAIT;
						end
					end
				end
				L_DATA: begin
					sh <= next_sh;
					cnt <= cnt + 4'h1;
					if (cnt == BYTE_LAST) begin
						cnt <= '0;
						if (ins == INS_ADDR_WRITE) begin
							sel <= next_sh;
							lstate <= L_IDLE;
						end else begin
							req_wr <= 1'b1;
							req_wd <= next_sh;
							req_sel <= sel;
							req_tog <= ~req_tog;
							oe <= 1'b1;
							lstate <= L_WAIT;
						end
					end
				end
				L_WAIT: begin
					if (ack_new) begin
						ack_seen <= ack_l2;
						dout <= 1'b1;
						sh <= link_rdata;
						cnt <= req_wr ? SEND_END : 4'h0;
						lstate <= L_SEND;
					end
				end
				L_SEND: begin
					if (cnt == SEND_END) begin
						oe <= 1'b0;
						dout <= 1'b0;
						lstate <= L_IDLE;
					end else begin
						dout <= sh[0];
						sh <= {1'b0, sh[7:1]};
						cnt <= cnt + 4'h1;
					end
				end
				default: begin
					oe <= 1'b0;
					lstate <= L_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// core domain: request crossing and registers
	// ------------------------------------------------------------
	logic req_c1;
	logic req_c2;
	logic req_seen;
	logic pend;
	logic [7:0] ctl;
	logic [7:0] data;
	logic [7:0] rev;
	logic rev_valid;
	logic expect_cmd;
	logic din_c1;
	logic din_c2;

	twdbg_stream_if #(.WIDTH(DATA_WIDTH)) fifo_in ();
	twdbg_stream_if #(.WIDTH(DATA_WIDTH)) fifo_out ();

	wire sel_data = req_sel == SEL_DATA;
	wire done = pend && (!req_wr || !sel_data || fifo_in.ready);
	wire ctl_write = done && req_wr && req_sel == SEL_CTL;
	wire data_write = done && req_wr && sel_data;
	wire sel_id = req_sel == SEL_PART_ID || req_sel == ADDR_PART_ID;
	wire sel_rev = req_sel == SEL_REV || req_sel == ADDR_REV;
	wire [7:0] rd_mux = sel_id ? PART_ID :
		sel_rev ? rev :
		req_sel == SEL_CTL ? ctl :
		sel_data ? data : 8'h00;
	wire sfr_page_hit = SFR_RD && SFR_PAGE == SFR_PAGE_DBG;
	wire sfr_id = sfr_page_hit && SFR_ADDR == ADDR_PART_ID;
	wire sfr_rev = sfr_page_hit && SFR_ADDR == ADDR_REV;
	wire [7:0] sfr_mux = sfr_id ? PART_ID :
		sfr_rev ? rev : 8'h00;
	wire ctl_en = ctl[CTL_EN_BIT];

	assign fifo_in.valid = pend && req_wr && sel_data;
	assign fifo_in.data = req_wd;
	assign fifo_out.ready = FLASH_READY && ctl_en;
	assign FLASH_VALID = fifo_out.valid && ctl_en;
	assign FLASH_DATA = fifo_out.data;

	twdbg_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(DEPTH)) u_fifo (
		.CLOCK(CLOCK),
		.RSTN(RSTN),
		.wr(fifo_in),
		.rd(fifo_out)
	);

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			req_c1 <= 1'b0;
			req_c2 <= 1'b0;
			din_c1 <= 1'b0;
			din_c2 <= 1'b0;
		end else begin
			req_c1 <= req_tog;
			req_c2 <= req_c1;
			din_c1 <= DBG_DATA_IN;
			din_c2 <= din_c1;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			req_seen <= 1'b0;
			pend <= 1'b0;
			ack_tog <= 1'b0;
			link_rdata <= '0;
		end else begin
			if (req_c2 != req_seen) begin
				req_seen <= req_c2;
				pend <= 1'b1;
			end else if (done) begin
				pend <= 1'b0;
				ack_tog <= ~ack_tog;
				link_rdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ctl <= CTL_RESET;
			data <= DATA_RESET;
			expect_cmd <= 1'b0;
			FP_CMD <= FC_NONE;
		end else begin
			if (ctl_write) begin
				ctl <= req_wd;
			end
			if (data_write) begin
				data <= req_wd;
			end else if (FLASH_RD_VALID) begin
				data <= FLASH_RD_DATA;
			end
			if (ctl_write && req_wd != CTL_RESET) begin
				expect_cmd <= 1'b1;
			end else if (data_write) begin
				expect_cmd <= 1'b0;
			end
			if (data_write && expect_cmd) begin
				FP_CMD <= twdbg_decode(req_wd);
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rev <= '0;
			rev_valid <= 1'b0;
			SFR_RDATA <= '0;
			PERIPH_STALL <= 1'b0;
			USER_PIN <= 1'b0;
		end else begin
			if (!rev_valid) begin
				rev <= REV_STRAP;
				rev_valid <= 1'b1;
			end
			SFR_RDATA <= sfr_mux;
			PERIPH_STALL <= HALTED;
			if (!HALTED) begin
				USER_PIN <= din_c2;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_part_id_sfr: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		sfr_id |=> SFR_RDATA == PART_ID)
		else $error("processor part identity read wrong");
	a_rev_sfr: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		sfr_rev |=> SFR_RDATA == rev)
		else $error("processor revision read wrong");
	a_part_id_link: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		done && !req_wr && req_sel == SEL_PART_ID |=> link_rdata == PART_ID)
		else $error("link part identity read wrong");
	a_rev_held: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		rev_valid |=> $stable(rev) && rev_valid)
		else $error("revision changed after capture");
	a_ctl_write: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		ctl_write |=> ctl == $past(req_wd) && !pend)
		else $error("control write not applied");
	a_data_push: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		data_write |-> fifo_in.valid && fifo_in.ready ##1 data == $past(req_wd))
		else $error("data byte not pushed");
	a_cmd_decode: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		data_write && expect_cmd && req_wd == CMD_PAGE_ERASE
		|=> FP_CMD == FC_PAGE)
		else $error("page erase not decoded");
	a_stall_halt: assert property (
		@(posedge CLOCK) disable iff (!RSTN)
		HALTED ##1 HALTED |-> PERIPH_STALL ##1 PERIPH_STALL)
		else $error("no stall while halted");
	a_pin_release: assert property (
		@(posedge DBG_CLK) disable iff (!RSTN)
		!halt_l2 |=> !oe && lstate == L_IDLE)
		else $error("data pin driven while running");
	a_wait_drives: assert property (
		@(posedge DBG_CLK) disable iff (!RSTN)
		lstate == L_WAIT |-> oe && !dout)
		else $error("wait bits not driven low");
	a_sel_update: assert property (
		@(posedge DBG_CLK) disable iff (!RSTN)
		halt_l2 && lstate == L_DATA && cnt == BYTE_LAST
		&& ins == INS_ADDR_WRITE |=> sel == $past(next_sh))
		else $error("select register not loaded");
endmodule : twdbg_target

// ===== verification/twdbg_host.sv
// host adapter model driving the two-wire debug link
// assumes the bench resolves the data line from both parties' enables
module twdbg_host
	import twdbg_pkg::*;
(
	output logic dbg_clk,
	output logic host_val,
	output logic host_en,
	input wire logic line,
	input wire logic oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic hung;
	initial begin
		dbg_clk = 1'b0;
		host_val = 1'b0;
		host_en = 1'b1;
		hung = 1'b0;
	end
	// ------------------------------------------------------------
	// one link period, clock only runs inside ticks
	// ------------------------------------------------------------
	task automatic tick(input logic v, input logic en);
		host_val = v;
		host_en = en;
		#12.2 dbg_clk = 1'b1;
		#17.8 dbg_clk = 1'b0;
	endtask : tick
	// ------------------------------------------------------------
	// one frame: start, instruction, data, wait, answer
	// ------------------------------------------------------------
	task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		rd = 8'h00;
		tick(1'b1, 1'b1);
		for (int i = 0; i < 2; i++) begin
			tick(ins[i], 1'b1);
		end
		if (ins[0]) begin
			for (int i = 0; i < 8; i++) begin
				tick(wd[i], 1'b1);
			end
		end
		if (ins == INS_ADDR_WRITE) begin
			tick(1'b0, 1'b1);
			return;
		end
		n = 0;
		// a select read shows ready at its last instruction rise
		while (!(oe === 1'b1 && line === 1'b1) && n < 64) begin
			tick(1'b0, 1'b0);
			n++;
		end
		if (n >= 64) begin
			hung = 1'b1;
		end
		if (!ins[0]) begin
			for (int i = 0; i < 8; i++) begin
				tick(1'b0, 1'b0);
				rd[i] = line;
			end
		end
		tick(1'b0, 1'b0);
		if (oe !== 1'b0) begin
			hung = 1'b1;
		end
		tick(1'b0, 1'b1);
	endtask : frame
endmodule : twdbg_host

// ===== verification/two_wire_debug_target_regs_tb.sv
// bench for the two-wire debug target register set
// assumes the host model twdbg_host and a 200 MHz core clock
module two_wire_debug_target_regs_tb
	import twdbg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] PART = 8'h3a; // arbitrary identity value
	localparam logic [7:0] REV = 8'h3c;
	logic CLOCK = 1'b0;
	logic RSTN, DBG_CLK, DBG_DATA_IN, DBG_DATA_OUT, DBG_DATA_OE, HALTED;
	logic PERIPH_STALL, USER_PIN, SFR_RD, FLASH_VALID, FLASH_READY;
	logic FLASH_RD_VALID, host_val, host_en;
	logic [7:0] REV_STRAP, SFR_ADDR, SFR_RDATA, FLASH_DATA, FLASH_RD_DATA;
	logic [3:0] SFR_PAGE;
	twdbg_cmd_type FP_CMD;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] d;
	logic [7:0] got[$];
	logic [7:0] code_t[5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h55};
	twdbg_cmd_type cmd_t[5] = '{FC_READ, FC_WRITE, FC_PAGE, FC_DEVICE,
		FC_NONE};
	logic [7:0] sel_t[4] = '{8'h00, 8'hfd, 8'h01, 8'hfe};
	assign DBG_DATA_IN = DBG_DATA_OE ? DBG_DATA_OUT :
		(host_en ? host_val : ~host_val);
	always #2.5 CLOCK = ~CLOCK;
	twdbg_target #(.PART_ID(PART), .DEPTH(32)) u_dut (.CLOCK, .RSTN,
		.DBG_CLK, .DBG_DATA_IN, .DBG_DATA_OUT, .DBG_DATA_OE, .HALTED,
		.PERIPH_STALL, .USER_PIN, .REV_STRAP, .SFR_RD, .SFR_ADDR,
		.SFR_PAGE, .SFR_RDATA, .FLASH_VALID, .FLASH_DATA, .FLASH_READY,
		.FLASH_RD_VALID, .FLASH_RD_DATA, .FP_CMD);
	twdbg_host u_host (.dbg_clk(DBG_CLK), .host_val(host_val),
		.host_en(host_en), .line(DBG_DATA_IN), .oe(DBG_DATA_OE));
	always @(posedge CLOCK) begin
		if (FLASH_VALID === 1'b1 && FLASH_READY === 1'b1) begin
			got.push_back(FLASH_DATA);
		end
		cycles++;
		if (cycles == 60000) begin
			failures++;
			final_report();
		end
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic final_report;
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic sfr(input logic [7:0] a, input logic [3:0] p,
		output logic [7:0] v);
		@(posedge CLOCK);
		#1 SFR_RD = 1'b1;
		SFR_ADDR = a;
		SFR_PAGE = p;
		@(posedge CLOCK);
		#1 SFR_RD = 1'b0;
		v = SFR_RDATA;
	endtask : sfr
	task automatic put(input logic [7:0] sel, input logic [7:0] v);
		logic [7:0] r;
		u_host.frame(INS_ADDR_WRITE, sel, r);
		u_host.frame(INS_DATA_WRITE, v, r);
	endtask : put
	task automatic get(input logic [7:0] sel, output logic [7:0] v);
		u_host.frame(INS_ADDR_WRITE, sel, v);
		u_host.frame(INS_DATA_READ, 8'h00, v);
	endtask : get
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		RSTN = 1'b0;
		HALTED = 1'b0;
		REV_STRAP = REV;
		SFR_RD = 1'b0;
		SFR_ADDR = 8'h00;
		SFR_PAGE = 4'h0;
		FLASH_READY = 1'b0;
		FLASH_RD_VALID = 1'b0;
		FLASH_RD_DATA = 8'h00;
		repeat (2) @(posedge CLOCK);
		#1 RSTN = 1'b1;
		check("fp_cmd", {5'h00, FP_CMD}, 8'h00);
		check("data_oe", {7'h00, DBG_DATA_OE}, 8'h00);
		sfr(ADDR_PART_ID, SFR_PAGE_DBG, d);
		check("sfr_id", d, PART);
		sfr(ADDR_REV, SFR_PAGE_DBG, d);
		check("sfr_rev", d, REV);
		sfr(ADDR_PART_ID, 4'h0, d);
		check("sfr_page0", d, 8'h00);
		u_host.frame(INS_ADDR_WRITE, SEL_CTL, d);
		u_host.tick(1'b1, 1'b1);
		repeat (6) @(posedge CLOCK);
		check("user_pin", {7'h00, USER_PIN}, 8'h01);
		#1 HALTED = 1'b1;
		repeat (2) @(posedge CLOCK);
		check("stall", {7'h00, PERIPH_STALL}, 8'h01);
		u_host.tick(1'b0, 1'b1);
		u_host.tick(1'b0, 1'b1);
		u_host.frame(INS_ADDR_READ, 8'h00, d);
		check("select_reset", d, SEL_RESET);
		for (int i = 0; i < 4; i++) begin
			get(sel_t[i], d);
			check("id_rev", d, i < 2 ? PART : REV);
		end
		put(SEL_PART_ID, 8'hff);
		get(SEL_PART_ID, d);
		check("id_ro", d, PART);
		get(SEL_CTL, d);
		check("ctl_reset", d, CTL_RESET);
		put(SEL_CTL, 8'ha5);
		get(SEL_CTL, d);
		check("ctl_rw", d, 8'ha5);
		check("user_frozen", {7'h00, USER_PIN}, 8'h01);
		#1 FLASH_READY = 1'b1;
		for (int i = 0; i < 5; i++) begin
			put(SEL_CTL, 8'h01);
			put(SEL_DATA, code_t[i]);
			repeat (4) @(posedge CLOCK);
			check("fp_cmd", {5'h00, FP_CMD}, {5'h00, cmd_t[i]});
		end
		check("pops", got.size(), 8'h05);
		for (int i = 0; i < 5; i++) begin
			check("stream", got[i], code_t[i]);
		end
		u_host.frame(INS_ADDR_READ, 8'h00, d);
		check("select_data", d, SEL_DATA);
		#1 FLASH_READY = 1'b0;
		got.delete();
		for (int i = 0; i < 32; i++) begin
			u_host.frame(INS_DATA_WRITE, 8'h40 + i[7:0], d);
		end
		check("fifo_head", FLASH_DATA, 8'h40);
		fork
			u_host.frame(INS_DATA_WRITE, 8'h60, d);
			begin
				repeat (200) @(posedge CLOCK);
				#1 FLASH_READY = 1'b1;
			end
		join
		repeat (80) @(posedge CLOCK);
		check("drained", got.size(), 8'h21);
		for (int i = 0; i < 33; i++) begin
			check("order", got[i], 8'h40 + i[7:0]);
		end
		@(posedge CLOCK);
		#1 FLASH_RD_DATA = 8'h9c;
		FLASH_RD_VALID = 1'b1;
		@(posedge CLOCK);
		#1 FLASH_RD_VALID = 1'b0;
		u_host.frame(INS_DATA_READ, 8'h00, d);
		check("flash_read", d, 8'h9c);
		check("link_ok", {7'h00, u_host.hung}, 8'h00);
		final_report();
	end
endmodule : two_wire_debug_target_regs_tb
